// ---- src/exc_pkg.sv ----
/*
  Shared constants and carrier types of the resource-conflict exception unit.
  Assumes a 32-bit APB register bus and a core that reports retiring writes per slot.
*/
package exc_pkg;
  // APB byte offsets
  localparam logic [7:0] OFF_FLAG = 8'h00;       // Exception flag register, read only
  localparam logic [7:0] OFF_CLEAR = 8'h04;      // Exception clear register, write only
  localparam logic [7:0] OFF_CAUSE = 8'h08;      // Internal cause register, read only
  localparam logic [7:0] OFF_RETURN = 8'h0c;     // Exception return pointer, read only
  localparam logic [7:0] OFF_TASK = 8'h10;       // Saved task state, read only
  localparam logic [7:0] OFF_VECTOR = 8'h14;     // Vector table pointer, read/write
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18; // Sticky events, cleared by read
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;   // Event mask, read/write
  localparam logic [7:0] OFF_CTRL = 8'h20;       // Control and diagnostic bits

  // Field positions
  localparam int EXC_FLAG_BIT = 1;   // Internal exception flag in the flag register
  localparam int CAUSE_CONFLICT_BIT = 0; // Write conflict cause in the cause register
  localparam int TSR_INT_BIT = 0;    // Interrupt flag in saved task state
  localparam int TSR_LOOP_BIT = 1;   // Loop active flag
  localparam int TSR_BRANCH_BIT = 2; // Branch in flight flag
  localparam int TSR_MODE_LSB = 3;   // Context mode field, two bits
  localparam int EV_CONFLICT = 0;    // Event: conflict seen
  localparam int EV_DEFERRED = 1;    // Event: deferred exception taken
  localparam int EV_IMMEDIATE = 2;   // Event: exception taken at once
  localparam int NUM_EVENTS = 3;
  localparam int CTRL_DETECT_EN = 0; // Conflict detection enable
  localparam int CTRL_VEC_MATCH = 8; // Read only: return pointer hits vector table

  // Values
  localparam logic [31:0] CLEAR_FLAG_VALUE = 32'h00000002;
  localparam logic [31:0] VEC_MATCH_MASK = 32'h0ffffe1f;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam logic [1:0] MODE_SUPERVISOR = 2'h0;

  // One retiring register write of the current cycle
  typedef struct packed {
    logic valid;         // Slot writes this cycle
    logic annulled;      // Instruction was annulled by a drain
    logic [2:0] latency; // Delay-slot class of the instruction
    logic [5:0] dest;    // Destination register number
  } write_slot_t;

  // Machine task state seen by the exception logic
  typedef struct packed {
    logic [1:0] context_mode_field;
    logic branch_in_flight_flag;
    logic loop_active_flag;
    logic int_flag;
  } task_state_t;
endpackage

// ---- src/conflict_detect.sv ----
/*
  Pairwise write-conflict detector over the retiring write slots.
  Assumes slots carry the annulled mark set by the pipeline drain logic.
*/
`timescale 1ns/1ps
module conflict_detect #(
  parameter int NUM_SLOTS = 4
) (
  input wire exc_pkg::write_slot_t [NUM_SLOTS-1:0] slots,
  input wire logic enable,
  output logic conflict
);
  localparam int NUM_PAIRS = NUM_SLOTS * NUM_SLOTS;

  // A slot takes part only if it really writes and was not annulled
  function automatic logic counts(input exc_pkg::write_slot_t s);
    counts = s.valid && !s.annulled;
  endfunction

  logic [NUM_PAIRS-1:0] hit; // One bit per ordered pair

  // Compare each pair once; lower pairs stay zero
  genvar i, j;
  generate
    for (i = 0; i < NUM_SLOTS; i++) begin : g_row
      for (j = 0; j < NUM_SLOTS; j++) begin : g_col
        if (j > i) begin : g_pair
          assign hit[i*NUM_SLOTS+j] = counts(slots[i]) && counts(slots[j]) && // RL3 RL12
                                      (slots[i].dest == slots[j].dest) &&
                                      (slots[i].latency != slots[j].latency); // RL1
        end else begin : g_none
          assign hit[i*NUM_SLOTS+j] = 1'b0;
        end
      end
    end
  endgenerate

  // Predicates from annulled packets never reach here, so no false hit
  assign conflict = enable && (|hit); // RL4
endmodule

// ---- src/exception_sequencer.sv ----
/*
  Decides when a detected conflict is taken: at once, or deferred to the handler.
  Assumes drain_active spans the interrupt drain and handler_reached pulses once.
*/
`timescale 1ns/1ps
module exception_sequencer (
  input wire logic clk,
  input wire logic reset,
  input wire logic conflict,
  input wire logic drain_active,
  input wire logic handler_reached,
  output logic take_immediate,
  output logic take_deferred,
  output logic pending
);
  typedef enum logic {SEQ_IDLE, SEQ_PENDING} seq_state_t;

  seq_state_t state_r; // Current state
  seq_state_t state_nxt; // Next state

  // Next state and take strobes
  always_comb begin
    state_nxt = state_r;
    take_immediate = 1'b0;
    take_deferred = 1'b0;
    case (state_r)
      SEQ_IDLE: begin
        // Seen during the drain: hold until the handler is reached
        if (conflict && drain_active) begin
          state_nxt = SEQ_PENDING; // RL5
        end else if (conflict) begin
          take_immediate = 1'b1;
        end
      end
      SEQ_PENDING: begin
        // Further conflicts fold into the one pending
        if (handler_reached) begin
          take_deferred = 1'b1; // RL5
          state_nxt = SEQ_IDLE;
        end
      end
      default: state_nxt = SEQ_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= SEQ_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pending = (state_r == SEQ_PENDING);
endmodule

// ---- src/resource_conflict_unit.sv ----
/*
  Resource-conflict exception unit: detection, deferral, capture of return
  pointer and task state, flag and cause registers, APB slave, interrupt.
  Assumes the core supplies retiring write slots, drain and handler strobes,
  the live pc and task state, and the handler fetch packet address.
*/
// Notes on behaviour
// RL1: Unequal-latency writes to one register raise conflict.
// RL2: Interrupt drain annuls in-flight instructions.
// RL3: Annulled instructions never enter conflict detection.
// RL4: Annulled predicate updates cannot fake conflicts.
// RL5: Conflict during drain waits for handler arrival.
// RL6: Deferred take captures state at handler arrival.
// RL7: Deferred task state: interrupt 1, others zero.
// RL8: Return pointer addresses interrupt service packet.
// RL9: Cause register sets only the conflict bit.
// RL10: Internal exception flag set on raising.
// RL11: Writing two to clear register clears flag.
// RL12: Every annulled instruction skips conflict checking.
`timescale 1ns/1ps
module resource_conflict_unit #(
  parameter int NUM_SLOTS = 4
) (
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  input wire exc_pkg::write_slot_t [NUM_SLOTS-1:0] slots,
  input wire logic drain_active,
  input wire logic handler_reached,
  input wire logic [31:0] exec_pc,
  input wire exc_pkg::task_state_t live_task_state,
  input wire logic [31:0] handler_fetch_addr,
  output logic annul_inflight,
  output logic exception_request,
  output logic exception_pending,
  output logic irq
);
  // Bus state
  logic pready_r; // Access phase answered
  logic pready_nxt;
  logic pslverr_r; // Unmapped address flagged
  logic pslverr_nxt;
  logic [31:0] prdata_r; // Read data held for the answer
  logic [31:0] prdata_nxt;
  // Exception state
  // Flag and cause always clear together, so software never sees them disagree
  logic exc_flag_r; // Internal exception flag
  logic exc_flag_nxt;
  logic cause_r; // Write conflict cause
  logic cause_nxt;
  logic [31:0] return_ptr_r; // Exception return pointer
  logic [31:0] return_ptr_nxt;
  exc_pkg::task_state_t saved_tsr_r; // Saved task state
  exc_pkg::task_state_t saved_tsr_nxt;
  logic [31:0] vector_ptr_r; // Vector table pointer
  logic [31:0] vector_ptr_nxt;
  logic [31:0] ctrl_r; // Control bits
  logic [31:0] ctrl_nxt;
  logic exc_req_r; // Exception request pulse to the core
  logic exc_req_nxt;
  logic pending_r; // Registered pending view
  logic annul_r; // Annul strobe to the pipeline
  logic annul_nxt;
  // Interrupt state
  logic [exc_pkg::NUM_EVENTS-1:0] irq_status_r; // Sticky events
  logic [exc_pkg::NUM_EVENTS-1:0] irq_status_nxt;
  logic [exc_pkg::NUM_EVENTS-1:0] irq_mask_r; // Event enables
  logic [exc_pkg::NUM_EVENTS-1:0] irq_mask_nxt;
  logic irq_r; // Interrupt output
  logic irq_nxt;
  // Internal strobes
  logic conflict; // Conflict this cycle
  logic take_immediate; // Take now
  logic take_deferred; // Take on handler arrival
  logic seq_pending; // Conflict waits for handler
  logic access; // Access phase of a transfer
  logic commit; // Transfer completes this edge
  logic wr_commit; // Write completes
  logic rd_commit; // Read completes
  logic clear_flag; // Clear register write hits the flag
  logic vec_match; // Return pointer lies in the vector table
  logic [31:0] tsr_word; // Saved task state as a word
  logic [exc_pkg::NUM_EVENTS-1:0] events; // Events of this cycle

  // True when an offset belongs to the map
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      exc_pkg::OFF_FLAG, exc_pkg::OFF_CLEAR, exc_pkg::OFF_CAUSE, exc_pkg::OFF_RETURN,
      exc_pkg::OFF_TASK, exc_pkg::OFF_VECTOR, exc_pkg::OFF_IRQ_STATUS,
      exc_pkg::OFF_IRQ_MASK, exc_pkg::OFF_CTRL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Detector over the retiring writes
  // Annulled slots are dropped inside the detector, never here, so that
  // a drain can not raise a conflict from writes that will not happen
  conflict_detect #(
    .NUM_SLOTS(NUM_SLOTS)
  ) u_detect (
    .slots(slots),
    .enable(ctrl_r[exc_pkg::CTRL_DETECT_EN]),
    .conflict(conflict)
  );

  // Decides between immediate and deferred take
  // A conflict seen during a drain is held back: taking it there would
  // save the state of a half-flushed pipeline that software can not
  // resume from, so it waits for the handler-arrival strobe
  exception_sequencer u_seq (
    .clk(clk),
    .reset(reset),
    .conflict(conflict),
    .drain_active(drain_active),
    .handler_reached(handler_reached),
    .take_immediate(take_immediate),
    .take_deferred(take_deferred),
    .pending(seq_pending)
  );

  // Bus phase decode
  assign access = psel && penable;
  assign commit = access && pready_r;
  assign wr_commit = commit && pwrite && !pslverr_r;
  assign rd_commit = commit && !pwrite && !pslverr_r;
  // The handler writes two here before returning through the saved pointer;
  // any value with that bit set clears, the other bits are ignored
  assign clear_flag = wr_commit && (paddr == exc_pkg::OFF_CLEAR) &&
                      ((pwdata & exc_pkg::CLEAR_FLAG_VALUE) != 32'h00000000); // RL11

  // Vector table hit under the fetch packet mask
  assign vec_match = ((return_ptr_r & exc_pkg::VEC_MATCH_MASK) ==
                      (vector_ptr_r & exc_pkg::VEC_MATCH_MASK)); // RL8

  // Saved task state laid out as a word
  always_comb begin
    tsr_word = 32'h00000000;
    tsr_word[exc_pkg::TSR_INT_BIT] = saved_tsr_r.int_flag;
    tsr_word[exc_pkg::TSR_LOOP_BIT] = saved_tsr_r.loop_active_flag;
    tsr_word[exc_pkg::TSR_BRANCH_BIT] = saved_tsr_r.branch_in_flight_flag;
    tsr_word[exc_pkg::TSR_MODE_LSB +: 2] = saved_tsr_r.context_mode_field;
  end

  // APB answer: one wait state, read data and error registered
  // The master still holds the access phase in the answer cycle, so
  // the error must drop by itself there: it stands beside pready only
  always_comb begin
    pready_nxt = access && !pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    // First access cycle: decode once and register the answer
    if (access && !pready_r) begin
      pslverr_nxt = !mapped(paddr);
      prdata_nxt = 32'h00000000;
      if (!pwrite) begin
        case (paddr)
          exc_pkg::OFF_FLAG: prdata_nxt[exc_pkg::EXC_FLAG_BIT] = exc_flag_r;
          exc_pkg::OFF_CAUSE: prdata_nxt[exc_pkg::CAUSE_CONFLICT_BIT] = cause_r; // RL9
          exc_pkg::OFF_RETURN: prdata_nxt = return_ptr_r;
          exc_pkg::OFF_TASK: prdata_nxt = tsr_word;
          exc_pkg::OFF_VECTOR: prdata_nxt = vector_ptr_r;
          exc_pkg::OFF_IRQ_STATUS: prdata_nxt[exc_pkg::NUM_EVENTS-1:0] = irq_status_r;
          exc_pkg::OFF_IRQ_MASK: prdata_nxt[exc_pkg::NUM_EVENTS-1:0] = irq_mask_r;
          exc_pkg::OFF_CTRL: begin
            prdata_nxt = ctrl_r;
            prdata_nxt[exc_pkg::CTRL_VEC_MATCH] = vec_match;
          end
          // Clear register and unmapped offsets read zero
          default: prdata_nxt = 32'h00000000;
        endcase
      end
    end
  end

  // Software registers
  always_comb begin
    vector_ptr_nxt = vector_ptr_r;
    irq_mask_nxt = irq_mask_r;
    ctrl_nxt = ctrl_r;
    if (wr_commit) begin
      case (paddr)
        exc_pkg::OFF_VECTOR: vector_ptr_nxt = pwdata;
        exc_pkg::OFF_IRQ_MASK: irq_mask_nxt = pwdata[exc_pkg::NUM_EVENTS-1:0];
        exc_pkg::OFF_CTRL: begin
          ctrl_nxt = 32'h00000000;
          ctrl_nxt[exc_pkg::CTRL_DETECT_EN] = pwdata[exc_pkg::CTRL_DETECT_EN];
        end
        // Other offsets hold no writable state here
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  // Flag, cause and capture of the machine state
  // A deferred take does not read the live pc or task state: on handler
  // arrival the saved values follow the interrupt-entry pattern, which
  // is what lets software tell a take inside a context switch apart
  always_comb begin
    exc_flag_nxt = exc_flag_r;
    cause_nxt = cause_r;
    return_ptr_nxt = return_ptr_r;
    saved_tsr_nxt = saved_tsr_r;
    exc_req_nxt = 1'b0;
    // Software clear first, so a take in the same cycle wins
    if (clear_flag) begin
      exc_flag_nxt = 1'b0; // RL11
      cause_nxt = 1'b0;
    end
    if (take_deferred) begin
      // State as it stands on arrival at the handler
      return_ptr_nxt = handler_fetch_addr; // RL6 RL8
      saved_tsr_nxt.int_flag = 1'b1; // RL7
      saved_tsr_nxt.loop_active_flag = 1'b0; // RL7
      saved_tsr_nxt.branch_in_flight_flag = 1'b0; // RL7
      saved_tsr_nxt.context_mode_field = exc_pkg::MODE_SUPERVISOR; // RL7
      // Conflict is the only cause kept, so no other cause bit can be set
      exc_flag_nxt = 1'b1; // RL10
      cause_nxt = 1'b1; // RL9
      exc_req_nxt = 1'b1;
    end else if (take_immediate) begin
      // Outside a drain the live state is saved
      return_ptr_nxt = exec_pc;
      saved_tsr_nxt = live_task_state;
      exc_flag_nxt = 1'b1; // RL10
      cause_nxt = 1'b1; // RL9
      exc_req_nxt = 1'b1;
    end
  end

  // Drain annuls every instruction still in flight
  // The strobe lags the drain by one cycle; the pipeline marks the
  // retiring slots itself, so the detector does not wait for it
  always_comb begin
    annul_nxt = drain_active; // RL2
  end

  // Sticky events, cleared by read, set wins over clear
  // The interrupt uses the next status and mask, so it follows a new
  // event, a mask write or a clearing read by exactly one cycle
  always_comb begin
    events = '0;
    events[exc_pkg::EV_CONFLICT] = conflict;
    events[exc_pkg::EV_DEFERRED] = take_deferred;
    events[exc_pkg::EV_IMMEDIATE] = take_immediate;
    irq_status_nxt = irq_status_r;
    if (rd_commit && (paddr == exc_pkg::OFF_IRQ_STATUS)) begin
      irq_status_nxt = '0;
    end
    irq_status_nxt = irq_status_nxt | events;
    irq_nxt = |(irq_status_nxt & irq_mask_nxt);
  end

  // Bus registers
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Software registers
  always_ff @(posedge clk) begin
    if (reset) begin
      vector_ptr_r <= 32'h00000000;
      irq_mask_r <= '0;
      ctrl_r <= exc_pkg::CTRL_RESET;
    end else begin
      vector_ptr_r <= vector_ptr_nxt;
      irq_mask_r <= irq_mask_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // Exception state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      // Nothing pending or flagged after reset
      exc_flag_r <= 1'b0;
      cause_r <= 1'b0;
      return_ptr_r <= 32'h00000000;
      saved_tsr_r <= '0;
      exc_req_r <= 1'b0;
      pending_r <= 1'b0;
      annul_r <= 1'b0;
    end else begin
      // Flag and cause move together
      exc_flag_r <= exc_flag_nxt;
      cause_r <= cause_nxt;
      return_ptr_r <= return_ptr_nxt;
      saved_tsr_r <= saved_tsr_nxt;
      exc_req_r <= exc_req_nxt;
      pending_r <= seq_pending;
      annul_r <= annul_nxt;
    end
  end

  // Interrupt registers
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Outputs straight from flip-flops
  // No output passes through logic, so the core and the bus see
  // clean values one clock after each decision, exception_pending two clocks after
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign annul_inflight = annul_r;
  assign exception_request = exc_req_r;
  assign exception_pending = pending_r;
  assign irq = irq_r;
endmodule

// ---- tb/rcu_properties.sv ----
/*
  Concurrent checks on the resource-conflict exception unit ports.
  Assumes conflict detection stays enabled as after reset.
*/
`timescale 1ns/1ps
module rcu_properties #(
  parameter int NUM_SLOTS = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire exc_pkg::write_slot_t [NUM_SLOTS-1:0] slots,
  input wire logic drain_active,
  input wire logic handler_reached,
  input wire logic annul_inflight,
  input wire logic exception_request,
  input wire logic exception_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic hit; // Live pair of unequal-latency writes to one register
  // Reference detector over the retiring slots
  always_comb begin
    hit = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++)
      for (int j = 0; j < NUM_SLOTS; j++)
        if (slots[i].valid && slots[j].valid && !slots[i].annulled && !slots[j].annulled &&
            slots[i].dest == slots[j].dest && slots[i].latency != slots[j].latency) hit = 1'b1;
  end
  // A request is a single-cycle pulse
  sequence take_s;
    exception_request ##1 !exception_request;
  endsequence
  req_pulse_a: assert property ($rose(exception_request) |-> take_s) else $error("request longer than one cycle");
  imm_take_a: assert property (hit && !drain_active && !exception_pending |=> exception_request)
    else $error("conflict not taken");
  defer_take_a: assert property (hit && drain_active |=> !exception_request ##[0:1] exception_pending)
    else $error("drain conflict not deferred");
  handler_take_a: assert property (exception_pending && handler_reached |=> exception_request)
    else $error("deferred exception not taken at handler");
  no_false_a: assert property (!hit && !handler_reached |=> !exception_request)
    else $error("request without live conflict");
  annul_on_a: assert property (drain_active |=> annul_inflight) else $error("drain not annulling");
  annul_off_a: assert property (!drain_active |=> !annul_inflight) else $error("annul without drain");
  apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer after wait");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
endmodule
bind resource_conflict_unit rcu_properties #(.NUM_SLOTS(NUM_SLOTS)) i_props (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .slots(slots),
  .drain_active(drain_active), .handler_reached(handler_reached), .annul_inflight(annul_inflight),
  .exception_request(exception_request), .exception_pending(exception_pending));

// ---- tb/core_model.sv ----
/*
  Core-side model: retires write packets, drains for interrupts, reaches the handler.
  Assumes the bench calls packet() from its main thread.
*/
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  output exc_pkg::write_slot_t [3:0] slots,
  output logic drain_active,
  output logic handler_reached,
  output logic [31:0] exec_pc,
  output exc_pkg::task_state_t live_task_state,
  output logic [31:0] handler_fetch_addr
);
  // Quiet core at time zero
  initial begin
    slots = '0;
    drain_active = 1'b0;
    handler_reached = 1'b0;
    exec_pc = '0;
    live_task_state = '0;
    handler_fetch_addr = '0;
  end
  // Two writes to one register; a drain ends on arrival at the handler after hold cycles
  task automatic packet(input logic drain, input logic annul, input logic same_lat, input int hold,
                        input logic [31:0] pc, input exc_pkg::task_state_t ts, input logic [31:0] hfa);
    @(posedge clk);
    drain_active <= drain;
    exec_pc <= pc;
    live_task_state <= ts;
    handler_fetch_addr <= hfa;
    slots[0] <= {1'b1, annul, 3'h1, 6'h05};
    slots[1] <= {1'b1, annul, same_lat ? 3'h1 : 3'h4, 6'h05};
    @(posedge clk);
    slots <= '0;
    repeat (hold) @(posedge clk);
    if (drain) begin
      handler_reached <= 1'b1;
      @(posedge clk);
      handler_reached <= 1'b0;
      drain_active <= 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask
endmodule

// ---- tb/test_resource_conflict_unit.sv ----
/*
  Self-checking bench for the resource-conflict exception unit.
  Assumes core_model drives the core side and rcu_properties is bound.
*/
`timescale 1ns/1ps
module test_resource_conflict_unit;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, annul_inflight, exception_request;
  logic exception_pending, irq, drain_active, handler_reached;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, exec_pc, handler_fetch_addr, pc, vec;
  exc_pkg::write_slot_t [3:0] slots;
  exc_pkg::task_state_t live_task_state, ts;
  logic [32:0] expq[$]; // Expected {error, read data} per transfer
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  resource_conflict_unit #(.NUM_SLOTS(4)) i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slots(slots), .drain_active(drain_active), .handler_reached(handler_reached), .exec_pc(exec_pc),
    .live_task_state(live_task_state), .handler_fetch_addr(handler_fetch_addr),
    .annul_inflight(annul_inflight), .exception_request(exception_request),
    .exception_pending(exception_pending), .irq(irq));
  core_model i_core (.clk(clk), .slots(slots), .drain_active(drain_active), .handler_reached(handler_reached),
    .exec_pc(exec_pc), .live_task_state(live_task_state), .handler_fetch_addr(handler_fetch_addr));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Counted comparison
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; d is write data or expected read data
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
    @(posedge clk);
    expq.push_back({err, wr ? 32'h0 : d});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Monitor: each completed transfer against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) check({pslverr, pwrite ? 32'h0 : prdata}, expq.pop_front());
  end
  // Ends the run in one place
  task automatic close_out();
    $display("counts compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    reset = 1'b1;
    void'($urandom(84));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // Reset values, bad offset, read-only write
    apb(0, exc_pkg::OFF_CTRL, 32'h101);
    apb(0, exc_pkg::OFF_FLAG, 32'h0);
    apb(1, 8'h24, 32'h0, 1'b1);
    apb(0, 8'h24, 32'h0, 1'b1);
    apb(1, exc_pkg::OFF_FLAG, 32'h2);
    apb(0, exc_pkg::OFF_FLAG, 32'h0);
    $display("test registers done");
    // Immediate conflict, interrupt masked then unmasked then cleared by read
    apb(1, exc_pkg::OFF_IRQ_MASK, 32'h0);
    pc = $urandom;
    ts = 5'($urandom);
    i_core.packet(1'b0, 1'b0, 1'b0, 0, pc, ts, 32'h0);
    check({32'h0, irq}, 33'h0);
    apb(1, exc_pkg::OFF_IRQ_MASK, 32'h7);
    repeat (2) @(posedge clk);
    check({32'h0, irq}, 33'h1);
    apb(0, exc_pkg::OFF_FLAG, 32'h2);
    apb(0, exc_pkg::OFF_CAUSE, 32'h1);
    apb(0, exc_pkg::OFF_RETURN, pc);
    apb(0, exc_pkg::OFF_TASK, {27'h0, ts});
    apb(0, exc_pkg::OFF_IRQ_STATUS, 32'h5);
    repeat (2) @(posedge clk);
    check({32'h0, irq}, 33'h0);
    apb(1, exc_pkg::OFF_CLEAR, exc_pkg::CLEAR_FLAG_VALUE);
    apb(0, exc_pkg::OFF_FLAG, 32'h0);
    $display("test immediate done");
    // Conflict during a drain, taken at the handler
    vec = $urandom & exc_pkg::VEC_MATCH_MASK;
    apb(1, exc_pkg::OFF_VECTOR, vec);
    i_core.packet(1'b1, 1'b0, 1'b0, 3, $urandom, 5'($urandom), vec | 32'hf00001e0);
    apb(0, exc_pkg::OFF_RETURN, vec | 32'hf00001e0);
    apb(0, exc_pkg::OFF_TASK, 32'h1);
    apb(0, exc_pkg::OFF_CTRL, 32'h101);
    apb(0, exc_pkg::OFF_FLAG, 32'h2);
    apb(0, exc_pkg::OFF_CAUSE, 32'h1);
    apb(0, exc_pkg::OFF_IRQ_STATUS, 32'h3);
    apb(0, exc_pkg::OFF_VECTOR, vec);
    apb(1, exc_pkg::OFF_CLEAR, 32'h2);
    $display("test deferred done");
    // Annulled packets in a drain, annulled or equal-latency outside it
    i_core.packet(1'b1, 1'b1, 1'b0, 2, $urandom, '0, 32'h0);
    i_core.packet(1'b0, 1'b1, 1'b0, 0, $urandom, '0, 32'h0);
    i_core.packet(1'b0, 1'b0, 1'b1, 0, $urandom, '0, 32'h0);
    apb(0, exc_pkg::OFF_FLAG, 32'h0);
    apb(0, exc_pkg::OFF_CAUSE, 32'h0);
    apb(0, exc_pkg::OFF_IRQ_STATUS, 32'h0);
    $display("test annulled done");
    repeat (3) @(posedge clk);
    close_out();
  end
endmodule
